// ===== design/cmfr_device.sv
// device end: config, sdram, spd copy, resets
// How it works
// - motherboard keeps image select static
// - flash bytes shifted serially into config input
// - mode register: burst four, latency two
// - control register reprograms latency and size
// - software sets control before using sdram
// - two sdram ports, alternating priority
// - eeprom clock is reference divided by 256
// - eeprom bytes framed by start, stop bits
// - eeprom copied into 64 word buffer
// - valid flag set once copy complete
// - buffer readable word by word
// - eeprom never written
// - processor reset asserts without clock
// - processor reset releases on falling edge
// - board detect selects reset source
// - module reset held until config done
// - button or software reset pulls line low
// - debug unit may pull module reset low
// - standalone module reset synchronised first
// - control register bit raises software reset
// - shared config done is low while any end holds it
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/1ps
module cmfr_device #(
    parameter int CFG_BYTES = cmfr_pkg::CFG_BYTES
) (
    cmfr_link_if.dev lnk,
    input wire logic aresetn,
    output logic [9:0] flash_addr,
    input wire logic [7:0] flash_data,
    output logic cfg_clk,
    output logic cfg_data,
    input wire logic spd_sda,
    output logic spd_scl,
    output logic sdram_mode_set,
    output logic [11:0] sdram_mode_word,
    output logic [1:0] sdram_cas,
    output logic [2:0] sdram_size
);
    // ************
    // state
    // ************
    typedef enum logic [1:0] {
        CFG_FETCH = 2'b00,
        CFG_LOAD = 2'b01,
        CFG_SHIFT = 2'b10,
        CFG_DONE = 2'b11
    } cmfr_cfg_t;

    typedef struct packed {
        logic [1:0] msr_s;
        logic [1:0] brd_s;
        logic [1:0] det_s;
        logic [1:0] btn_s;
        logic [1:0] done_s;
        logic [1:0] img_s1;
        logic [1:0] img_s2;
        logic rel_a;
        logic rel_b;
        logic [7:0] software_reset_cnt;
        logic [1:0] cas;
        logic [2:0] size;
        logic mode_pend;
        logic mode_set;
        logic [11:0] mode_word;
        logic prio_board;
        logic gnt_cpu;
        logic gnt_board;
        logic ack;
        logic err;
        logic [31:0] rdata;
        cmfr_cfg_t cfg;
        logic [7:0] cfg_idx;
        logic [7:0] cfg_sh;
        logic [2:0] cfg_bit;
        logic cfg_ph;
        logic [1:0] cfg_img;
    } cmfr_dev_t;

    cmfr_dev_t q, d;
    logic rel_q;
    logic [31:0] spd_word;
    logic spd_valid;
    logic src_raw_n;
    logic sel_sync_n;
    logic in_spd;

    cmfr_spd_reader u_spd (
        .aclk(lnk.aclk),
        .aresetn(aresetn),
        .sda_in(spd_sda),
        .scl(spd_scl),
        .rd_index(lnk.reg_addr[7:2]),
        .rd_data(spd_word),
        .valid(spd_valid)
    );

    assign in_spd = (lnk.reg_addr >= cmfr_pkg::SPD_FIRST_ADDR) && (lnk.reg_addr <= cmfr_pkg::SPD_LAST_ADDR)
        && (lnk.reg_addr[1:0] == 2'h0);

    always_comb begin
        d = q;
        // pin synchronisers
        d.msr_s = {q.msr_s[0], lnk.module_system_reset_n};
        d.brd_s = {q.brd_s[0], lnk.board_system_reset_n};
        d.det_s = {q.det_s[0], lnk.board_detect_n};
        d.btn_s = {q.btn_s[0], lnk.button_reset};
        d.done_s = {q.done_s[0], !lnk.shared_config_done};
        d.img_s1 = lnk.image_select;
        d.img_s2 = q.img_s1;
        // processor reset release, posedge part
        d.rel_a = sel_sync_n;
        d.rel_b = q.rel_a;
        // software reset stretch
        if (q.software_reset_cnt != 8'h00) begin
            d.software_reset_cnt = q.software_reset_cnt - 8'h01;
        end
        // mode register
        d.mode_set = 1'b0;
        if (q.mode_pend) begin
            d.mode_set = 1'b1;
            d.mode_word = {5'h00, 1'b0, q.cas, 1'b0, cmfr_pkg::BURST_FOUR_CODE};
            d.mode_pend = 1'b0;
        end
        // two-port arbiter
        d.gnt_cpu = lnk.sd_req_cpu && (!lnk.sd_req_board || !q.prio_board);
        d.gnt_board = lnk.sd_req_board && !d.gnt_cpu;
        if (d.gnt_cpu || d.gnt_board) begin
            d.prio_board = d.gnt_cpu;
        end
        // register port
        d.ack = lnk.reg_req && !q.ack;
        d.err = 1'b0;
        d.rdata = 32'h0;
        if (lnk.reg_req && !q.ack) begin
            if (lnk.reg_addr == cmfr_pkg::SDRAM_CTRL_ADDR) begin
                d.rdata[cmfr_pkg::CAS_LSB +: 2] = q.cas;
                d.rdata[cmfr_pkg::SIZE_LSB +: 3] = q.size;
                d.rdata[cmfr_pkg::SPD_VALID_BIT] = spd_valid;
                if (lnk.reg_wr) begin
                    d.cas = lnk.reg_wdata[cmfr_pkg::CAS_LSB +: 2];
                    d.size = lnk.reg_wdata[cmfr_pkg::SIZE_LSB +: 3];
                    d.mode_pend = 1'b1;
                end
            end else if (lnk.reg_addr == cmfr_pkg::MOD_CTRL_ADDR) begin
                d.rdata[cmfr_pkg::SOFTWARE_RESET_BIT] = (q.software_reset_cnt != 8'h00);
                if (lnk.reg_wr && lnk.reg_wdata[cmfr_pkg::SOFTWARE_RESET_BIT]) begin
                    d.software_reset_cnt = cmfr_pkg::SOFTWARE_RESET_CYCLES;
                end
            end else if (in_spd) begin
                // copy is read only; writes go nowhere
                d.rdata = spd_word;
                d.err = lnk.reg_wr;
            end else begin
                d.err = 1'b1;
            end
        end
        // configuration loader
        unique case (q.cfg)
            CFG_FETCH: begin
                d.cfg_img = q.img_s2;
                d.cfg = CFG_LOAD;
            end
            CFG_LOAD: begin
                d.cfg_sh = flash_data;
                d.cfg_bit = 3'h0;
                d.cfg_ph = 1'b0;
                d.cfg = CFG_SHIFT;
            end
            CFG_SHIFT: begin
                d.cfg_ph = !q.cfg_ph;
                if (q.cfg_ph) begin
                    d.cfg_sh = {q.cfg_sh[6:0], 1'b0};
                    d.cfg_bit = q.cfg_bit + 3'h1;
                    if (q.cfg_bit == 3'h7) begin
                        d.cfg_idx = q.cfg_idx + 8'h01;
                        d.cfg = (q.cfg_idx == 8'(CFG_BYTES - 1)) ? CFG_DONE : CFG_LOAD;
                    end
                end
            end
            CFG_DONE: begin
                d.cfg = CFG_DONE;
            end
        endcase
    end

    always_ff @(posedge lnk.aclk) begin
        if (!aresetn) begin
            q <= '0;
            q.det_s <= 2'h3;
            q.done_s <= 2'h3;
            q.cas <= cmfr_pkg::CAS_RESET;
            q.size <= cmfr_pkg::SIZE_RESET;
            q.mode_pend <= 1'b1;
            q.cfg <= CFG_FETCH;
        end else begin
            q <= d;
        end
    end

    // release stage on the falling edge; assertion bypasses it
    always_ff @(negedge lnk.aclk) begin
        if (!aresetn) begin
            rel_q <= 1'b0;
        end else begin
            rel_q <= q.rel_b && sel_sync_n;
        end
    end

    // ************
    // outputs: resets, register port, arbiter, flash, sdram
    // ************
    // raw selection so assertion needs no clock edge
    assign src_raw_n = lnk.board_detect_n ? lnk.module_system_reset_n : lnk.board_system_reset_n;
    assign sel_sync_n = q.det_s[1] ? q.msr_s[1] : q.brd_s[1];
    assign lnk.processor_reset_n = src_raw_n && rel_q;
    // pull low only; line read back through msr_s
    assign lnk.msr_dev_oe = q.btn_s[1] || (q.software_reset_cnt != 8'h00) || q.done_s[1];
    assign lnk.cfg_dev_hold = (q.cfg != CFG_DONE);
    assign lnk.reg_ack = q.ack;
    assign lnk.reg_err = q.err;
    assign lnk.reg_rdata = q.rdata;
    assign lnk.sd_gnt_cpu = q.gnt_cpu;
    assign lnk.sd_gnt_board = q.gnt_board;
    assign flash_addr = {q.cfg_img, q.cfg_idx};
    assign cfg_clk = q.cfg_ph;
    assign cfg_data = q.cfg_sh[7];
    assign sdram_mode_set = q.mode_set;
    assign sdram_mode_word = q.mode_word;
    assign sdram_cas = q.cas;
    assign sdram_size = q.size;
endmodule // cmfr_device

// ===== design/cmfr_host.sv
// host end, steered over axi4-lite
`timescale 1ns/1ps
module cmfr_host (
    cmfr_link_if.host lnk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    typedef struct packed {
        logic aw_got;
        logic [11:0] aw_addr;
        logic w_got;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [8:0] ctrl;
        logic [31:0] dev_addr;
        logic [31:0] dev_wdata;
        logic busy;
        logic dev_wr;
        logic err;
        logic [31:0] dev_rdata;
        logic seen_cpu;
        logic seen_board;
    } cmfr_host_t;

    cmfr_host_t q, d;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    always_comb begin
        logic [31:0] c;
        c = merge({23'h0, q.ctrl}, q.w_data, q.w_strb);
        d = q;
        d.seen_cpu = q.seen_cpu || lnk.sd_gnt_cpu;
        d.seen_board = q.seen_board || lnk.sd_gnt_board;
        if (q.busy && lnk.reg_ack) begin
            d.busy = 1'b0;
            d.err = lnk.reg_err;
            d.dev_rdata = lnk.reg_rdata;
        end
        if (s_axi_awvalid && s_axi_awready) begin
            d.aw_got = 1'b1;
            d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            d.w_got = 1'b1;
            d.w_data = s_axi_wdata;
            d.w_strb = s_axi_wstrb;
        end
        if (q.aw_got && q.w_got) begin
            d.aw_got = 1'b0;
            d.w_got = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = cmfr_pkg::RESP_OKAY;
            unique case (q.aw_addr)
                cmfr_pkg::H_CTRL: begin
                    d.ctrl = c[8:0];
                    // image select frozen once configuration is released
                    if (!q.ctrl[8]) begin
                        d.ctrl[1:0] = q.ctrl[1:0];
                    end
                end
                cmfr_pkg::H_DEV_ADDR: d.dev_addr = merge(q.dev_addr, q.w_data, q.w_strb);
                cmfr_pkg::H_DEV_WDATA: d.dev_wdata = merge(q.dev_wdata, q.w_data, q.w_strb);
                cmfr_pkg::H_DEV_CMD: begin
                    // a command while one is open is dropped
                    if (!q.busy && q.w_strb[0] && q.w_data[0]) begin
                        d.busy = 1'b1;
                        d.dev_wr = q.w_data[1];
                    end
                end
                default: d.bresp = cmfr_pkg::RESP_SLVERR;
            endcase
        end
        if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            d.rvalid = 1'b1;
            d.rresp = cmfr_pkg::RESP_OKAY;
            unique case (s_axi_araddr)
                cmfr_pkg::H_CTRL: d.rdata = {23'h0, q.ctrl};
                cmfr_pkg::H_DEV_ADDR: d.rdata = q.dev_addr;
                cmfr_pkg::H_DEV_WDATA: d.rdata = q.dev_wdata;
                cmfr_pkg::H_DEV_CMD: d.rdata = {31'h0, q.busy};
                cmfr_pkg::H_STATUS: d.rdata = {25'h0, lnk.shared_config_done, lnk.module_system_reset_n,
                    q.seen_board, q.seen_cpu, lnk.processor_reset_n, q.err, q.busy};
                cmfr_pkg::H_DEV_RDATA: d.rdata = q.dev_rdata;
                default: begin
                    d.rdata = 32'h0;
                    d.rresp = cmfr_pkg::RESP_SLVERR;
                end
            endcase
            if (s_axi_araddr == cmfr_pkg::H_STATUS) begin
                d.seen_cpu = lnk.sd_gnt_cpu;
                d.seen_board = lnk.sd_gnt_board;
            end
        end
        if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
        end
    end

    always_ff @(posedge lnk.aclk) begin
        if (!aresetn) begin
            q <= '0;
            q.ctrl <= cmfr_pkg::H_CTRL_RESET;
        end else begin
            q <= d;
        end
    end

    assign s_axi_awready = !q.aw_got && !q.bvalid;
    assign s_axi_wready = !q.w_got && !q.bvalid;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_arready = !q.rvalid;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rdata = q.rdata;
    assign s_axi_rresp = q.rresp;
    assign lnk.image_select = q.ctrl[1:0];
    assign lnk.board_detect_n = q.ctrl[2];
    assign lnk.button_reset = q.ctrl[3];
    assign lnk.msr_dbg_oe = q.ctrl[4];
    assign lnk.board_system_reset_n = q.ctrl[5];
    assign lnk.sd_req_cpu = q.ctrl[6];
    assign lnk.sd_req_board = q.ctrl[7];
    assign lnk.cfg_other_hold = q.ctrl[8];
    assign lnk.reg_req = q.busy;
    assign lnk.reg_wr = q.dev_wr;
    assign lnk.reg_addr = q.dev_addr;
    assign lnk.reg_wdata = q.dev_wdata;
endmodule // cmfr_host

// ===== design/cmfr_spd_reader.sv
// presence-detect eeprom reader and its 64-word copy
`timescale 1ns/1ps
module cmfr_spd_reader #(
    parameter int DIV = cmfr_pkg::SPD_DIV,
    parameter int WORDS = cmfr_pkg::SPD_WORDS
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic sda_in,
    output logic scl,
    input wire logic [5:0] rd_index,
    output logic [31:0] rd_data,
    output logic valid
);
    localparam logic [7:0] HALF_M1 = 8'((DIV / 2) - 1);

    typedef struct packed {
        logic sda_s1;
        logic sda_s2;
        logic [7:0] div;
        logic scl;
        logic [3:0] slot;
        logic [7:0] shift;
        logic [7:0] byte_n;
        logic done;
        logic [WORDS-1:0][31:0] mem;
    } cmfr_spd_t;

    cmfr_spd_t q, d;

    always_comb begin
        d = q;
        d.sda_s1 = sda_in;
        d.sda_s2 = q.sda_s1;
        if (!q.done) begin
            d.div = q.div + 8'h01;
            if (q.div == HALF_M1) begin
                // 256 cycles per scl period
                d.div = 8'h00;
                d.scl = !q.scl;
                if (!q.scl) begin
                    // sample on rising scl: start, 8 data msb first, stop
                    if (q.slot == 4'h0) begin
                        if (!q.sda_s2) begin
                            d.slot = 4'h1;
                        end
                    end else if (q.slot != cmfr_pkg::SPD_STOP_SLOT) begin
                        d.shift = {q.shift[6:0], q.sda_s2};
                        d.slot = q.slot + 4'h1;
                    end else begin
                        d.slot = 4'h0;
                        // bad stop bit drops the byte and waits for a new start
                        if (q.sda_s2) begin
                            d.mem[q.byte_n[7:2]][q.byte_n[1:0]*8 +: 8] = q.shift;
                            d.byte_n = q.byte_n + 8'h01;
                            d.done = (q.byte_n == cmfr_pkg::SPD_LAST_BYTE);
                        end
                    end
                end
            end
        end else begin
            d.scl = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
            q.scl <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign scl = q.scl;
    assign rd_data = q.mem[rd_index];
    assign valid = q.done;
endmodule // cmfr_spd_reader

// ===== inc/cmfr_link_if.sv
// link between the two ends
`timescale 1ns/1ps
interface cmfr_link_if (
    input wire logic aclk
);
    logic reg_req;
    logic reg_wr;
    logic [31:0] reg_addr;
    logic [31:0] reg_wdata;
    logic reg_ack;
    logic reg_err;
    logic [31:0] reg_rdata;
    logic sd_req_cpu;
    logic sd_req_board;
    logic sd_gnt_cpu;
    logic sd_gnt_board;
    logic [1:0] image_select;
    logic board_detect_n;
    logic button_reset;
    logic board_system_reset_n;
    logic msr_dev_oe;
    logic msr_dbg_oe;
    logic module_system_reset_n;
    logic cfg_dev_hold;
    logic cfg_other_hold;
    logic shared_config_done;
    logic processor_reset_n;

    // open-collector lines: any driver pulls low
    assign module_system_reset_n = !(msr_dev_oe | msr_dbg_oe);
    assign shared_config_done = !(cfg_dev_hold | cfg_other_hold);

    modport dev (
        input aclk, reg_req, reg_wr, reg_addr, reg_wdata, sd_req_cpu, sd_req_board,
        input image_select, board_detect_n, button_reset, board_system_reset_n,
        input module_system_reset_n, shared_config_done,
        output reg_ack, reg_err, reg_rdata, sd_gnt_cpu, sd_gnt_board, msr_dev_oe,
        output cfg_dev_hold, processor_reset_n
    );
    modport host (
        input aclk, reg_ack, reg_err, reg_rdata, sd_gnt_cpu, sd_gnt_board,
        input module_system_reset_n, shared_config_done, processor_reset_n,
        output reg_req, reg_wr, reg_addr, reg_wdata, sd_req_cpu, sd_req_board,
        output image_select, board_detect_n, button_reset, board_system_reset_n,
        output msr_dbg_oe, cfg_other_hold
    );
endinterface

// ===== inc/cmfr_pkg.sv
// shared constants
package cmfr_pkg;
    // ************
    // device register map
    // ************
    localparam logic [31:0] SDRAM_CTRL_ADDR = 32'h10000020;
    localparam logic [31:0] MOD_CTRL_ADDR = 32'h1000000c;
    localparam logic [31:0] SPD_FIRST_ADDR = 32'h10000100;
    localparam logic [31:0] SPD_LAST_ADDR = 32'h100001fc;
    localparam int CAS_LSB = 0;
    localparam int SIZE_LSB = 2;
    localparam int SPD_VALID_BIT = 5;
    localparam int SOFTWARE_RESET_BIT = 3;
    localparam logic [1:0] CAS_RESET = 2'h2;
    localparam logic [2:0] SIZE_RESET = 3'h0;
    localparam logic [2:0] BURST_FOUR_CODE = 3'h2;
    localparam logic [7:0] SOFTWARE_RESET_CYCLES = 8'h10;
    // ************
    // presence-detect serial link, config image length
    // ************
    localparam int SPD_DIV = 256;
    localparam int SPD_WORDS = 64;
    localparam logic [7:0] SPD_LAST_BYTE = 8'hff;
    localparam logic [3:0] SPD_STOP_SLOT = 4'h9;
    localparam int CFG_BYTES = 16;
    // ************
    // host register map
    // ************
    localparam logic [11:0] H_CTRL = 12'h000;
    localparam logic [11:0] H_DEV_ADDR = 12'h004;
    localparam logic [11:0] H_DEV_WDATA = 12'h008;
    localparam logic [11:0] H_DEV_CMD = 12'h00c;
    localparam logic [11:0] H_STATUS = 12'h010;
    localparam logic [11:0] H_DEV_RDATA = 12'h014;
    localparam logic [8:0] H_CTRL_RESET = 9'h124;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== tb/cmfr_link_properties.sv
// link checks
`timescale 1ns/1ps
module cmfr_link_properties (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic reg_req,
    input wire logic reg_wr,
    input wire logic [31:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_ack,
    input wire logic reg_err,
    input wire logic sd_req_cpu,
    input wire logic sd_req_board,
    input wire logic sd_gnt_cpu,
    input wire logic sd_gnt_board,
    input wire logic board_detect_n,
    input wire logic button_reset,
    input wire logic board_system_reset_n,
    input wire logic module_system_reset_n,
    input wire logic shared_config_done,
    input wire logic processor_reset_n
);
    // ************
    // properties
    // ************
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence s_both_req;
        sd_req_cpu && sd_req_board;
    endsequence
    sequence s_spd_ack;
        reg_ack && reg_addr >= cmfr_pkg::SPD_FIRST_ADDR && reg_addr <= cmfr_pkg::SPD_LAST_ADDR;
    endsequence
    sequence s_software_reset_take;
        reg_req && !reg_ack && reg_wr && reg_addr == cmfr_pkg::MOD_CTRL_ADDR && reg_wdata[cmfr_pkg::SOFTWARE_RESET_BIT];
    endsequence
    property p_gnt_one; !(sd_gnt_cpu && sd_gnt_board); endproperty
    a_gnt_one: assert property (p_gnt_one) else $error("grant overlap");
    property p_alt_cpu; sd_gnt_cpu ##0 s_both_req |=> sd_gnt_board; endproperty
    a_alt_cpu: assert property (p_alt_cpu) else $error("no alternation");
    property p_spd_wr; s_spd_ack ##0 reg_wr |-> reg_err; endproperty
    a_spd_wr: assert property (p_spd_wr) else $error("copy write taken");
    property p_spd_rd; s_spd_ack ##0 !reg_wr |-> !reg_err; endproperty
    a_spd_rd: assert property (p_spd_rd) else $error("copy read refused");
    property p_standalone; board_detect_n && !module_system_reset_n |-> !processor_reset_n; endproperty
    a_standalone: assert property (p_standalone) else $error("module reset lost");
    property p_board; !board_detect_n && !board_system_reset_n |-> !processor_reset_n; endproperty
    a_board: assert property (p_board) else $error("board reset lost");
    property p_done; !shared_config_done |-> !module_system_reset_n; endproperty
    a_done: assert property (p_done) else $error("early release");
    property p_button; button_reset [*4] |-> !module_system_reset_n; endproperty
    a_button: assert property (p_button) else $error("button ignored");
    property p_sync; $rose(processor_reset_n) && board_detect_n |-> $past(module_system_reset_n, 2); endproperty
    a_sync: assert property (p_sync) else $error("unsynced release");
    property p_software_reset; s_software_reset_take |-> ##[1:4] !module_system_reset_n; endproperty
    a_software_reset: assert property (p_software_reset) else $error("soft reset lost");
endmodule // cmfr_link_properties

// ===== tb/tb_top.sv
// bench joining both ends
`timescale 1ns/1ps
module tb_top;
    logic aclk = 1'b0, aresetn = 1'b0, awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
    logic [11:0] awa = 12'h000, ara = 12'h000;
    logic [31:0] wd = 32'h0, rd, d;
    logic [7:0] fd = 8'h00;
    logic awr, wr, bv, arr, rv, ms, scl, e;
    logic [1:0] bre, rre, rsp, cas;
    logic [2:0] size;
    logic [11:0] mw;
    logic [9:0] fa;
    int n_fail, n_tests, n_mode;
    cmfr_link_if lnk (.aclk(aclk));
    // short config image keeps boot quick
    cmfr_device #(.CFG_BYTES(2)) cmfr_device_i (.lnk(lnk.dev), .aresetn(aresetn), .flash_addr(fa),
        .flash_data(fd), .cfg_clk(), .cfg_data(), .spd_sda(1'b1), .spd_scl(scl), .sdram_mode_set(ms),
        .sdram_mode_word(mw), .sdram_cas(cas), .sdram_size(size));
    cmfr_host cmfr_host_i (.lnk(lnk.host), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr),
        .s_axi_bresp(bre), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rre), .s_axi_rvalid(rv), .s_axi_rready(rr));
    cmfr_link_properties cmfr_link_properties_i (.aclk(aclk), .aresetn(aresetn), .reg_req(lnk.reg_req),
        .reg_wr(lnk.reg_wr), .reg_addr(lnk.reg_addr), .reg_wdata(lnk.reg_wdata), .reg_ack(lnk.reg_ack),
        .reg_err(lnk.reg_err), .sd_req_cpu(lnk.sd_req_cpu), .sd_req_board(lnk.sd_req_board),
        .sd_gnt_cpu(lnk.sd_gnt_cpu), .sd_gnt_board(lnk.sd_gnt_board), .board_detect_n(lnk.board_detect_n),
        .button_reset(lnk.button_reset), .board_system_reset_n(lnk.board_system_reset_n),
        .module_system_reset_n(lnk.module_system_reset_n), .shared_config_done(lnk.shared_config_done),
        .processor_reset_n(lnk.processor_reset_n));
    // ************
    // helpers
    // ************
    always @(posedge aclk) begin
        fd <= fa[7:0] ^ 8'h5a;
        if (ms === 1'b1) n_mode <= n_mode + 1;
    end
    always @(posedge lnk.processor_reset_n) chk(32'(aclk), 32'h0);
    task stop_test;
        if (n_fail == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] x);
        n_tests++;
        if (s !== x) begin
            n_fail++;
            $display("[ERR] %0t seen %h expected %h", $time, s, x);
        end
    endtask
    task lim(input int n, input int m);
        if (n >= m) begin
            n_fail++;
            $display("[ERR] %0t wait ran out", $time);
            stop_test();
        end
    endtask
    task axi_wr(input logic [11:0] a, input logic [31:0] v);
        int n;
        @(posedge aclk);
        awa <= a;
        wd <= v;
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (awr) awv <= 1'b0;
            if (wr) wv <= 1'b0;
            if (bv) break;
        end
        br <= 1'b0;
        lim(n, 100);
    endtask
    task axi_rd(input logic [11:0] a);
        int n;
        @(posedge aclk);
        ara <= a;
        arv <= 1'b1;
        rr <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (arr) arv <= 1'b0;
            if (rv) break;
        end
        d = rd;
        rsp = rre;
        rr <= 1'b0;
        lim(n, 100);
    endtask
    task cmd(input logic w, input logic [31:0] a, input logic [31:0] v);
        axi_wr(cmfr_pkg::H_DEV_ADDR, a);
        axi_wr(cmfr_pkg::H_DEV_WDATA, v);
        axi_wr(cmfr_pkg::H_DEV_CMD, {30'h0, w, 1'b1});
    endtask
    // e: error flag, d: read data
    task dev(input logic w, input logic [31:0] a, input logic [31:0] v);
        int n;
        cmd(w, a, v);
        for (n = 0; n < 20; n++) begin
            axi_rd(cmfr_pkg::H_DEV_CMD);
            if (d[0] === 1'b0) break;
        end
        lim(n, 20);
        axi_rd(cmfr_pkg::H_STATUS);
        e = d[1];
        axi_rd(cmfr_pkg::H_DEV_RDATA);
    endtask
    task wait_prn(input logic v);
        int n;
        for (n = 0; n < 400; n++) begin
            @(posedge aclk);
            if (lnk.processor_reset_n === v) break;
        end
        lim(n, 400);
    endtask
    // ************
    // scenarios
    // ************
    task t_reset;
        chk(32'(lnk.module_system_reset_n), 32'h0);
        axi_rd(cmfr_pkg::H_CTRL);
        chk(d, 32'h124);
        chk(32'(cas), 32'(cmfr_pkg::CAS_RESET));
        chk(32'(mw[2:0]), 32'(cmfr_pkg::BURST_FOUR_CODE));
        chk(32'(n_mode), 32'h1);
        axi_rd(12'h020);
        chk(32'(rsp), 32'(cmfr_pkg::RESP_SLVERR));
    endtask
    task t_boot;
        axi_wr(cmfr_pkg::H_CTRL, 32'h024);
        wait_prn(1'b1);
        chk(32'(lnk.shared_config_done), 32'h1);
        chk(32'(lnk.module_system_reset_n), 32'h1);
    endtask
    task t_dev;
        dev(1'b0, cmfr_pkg::SDRAM_CTRL_ADDR, 32'h0);
        chk(d, 32'h2);
        dev(1'b1, cmfr_pkg::SDRAM_CTRL_ADDR, 32'h17);
        chk(32'({size, cas}), 32'h17);
        chk(32'(n_mode), 32'h2);
        dev(1'b1, cmfr_pkg::SPD_FIRST_ADDR, 32'h1);
        chk(32'(e), 32'h1);
        dev(1'b0, cmfr_pkg::SPD_LAST_ADDR, 32'h0);
        chk(32'(e), 32'h0);
        dev(1'b0, 32'h10000200, 32'h0);
        chk(32'(e), 32'h1);
    endtask
    task t_resets;
        cmd(1'b1, cmfr_pkg::MOD_CTRL_ADDR, 32'h8);
        wait_prn(1'b0);
        chk(32'(lnk.module_system_reset_n), 32'h0);
        wait_prn(1'b1);
        axi_wr(cmfr_pkg::H_CTRL, 32'h02c);
        repeat (4) @(posedge aclk);
        chk(32'({lnk.module_system_reset_n, lnk.processor_reset_n}), 32'h0);
        axi_wr(cmfr_pkg::H_CTRL, 32'h034);
        repeat (4) @(posedge aclk);
        chk(32'(lnk.processor_reset_n), 32'h0);
        axi_wr(cmfr_pkg::H_CTRL, 32'h024);
        wait_prn(1'b1);
    endtask
    task t_arb_board;
        axi_wr(cmfr_pkg::H_CTRL, 32'h0e4);
        repeat (6) @(posedge aclk);
        axi_rd(cmfr_pkg::H_STATUS);
        chk(32'(d[4:3]), 32'h3);
        axi_wr(cmfr_pkg::H_CTRL, 32'h028);
        repeat (4) @(posedge aclk);
        chk(32'({lnk.module_system_reset_n, lnk.processor_reset_n}), 32'h1);
        axi_wr(cmfr_pkg::H_CTRL, 32'h008);
        chk(32'(lnk.processor_reset_n), 32'h0);
    endtask
    initial begin
        forever #10 aclk = ~aclk;
    end
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (4) @(posedge aclk);
        t_reset();
        t_boot();
        t_dev();
        t_resets();
        t_arb_board();
        stop_test();
    end
endmodule // tb_top
